//--- common/vsc_cfg.svh
// Summary of operation
// - Passive zero held 64 us, 62 to 66
// - Passive one held 128 us, 126 to 130
// - Active zero driven 128 us, 126 to 130
// - Active one driven 64 us, 62 to 66
// - Frame opens with 200 us active start
// - End of data is 200 us passive
// - Frame ends after 280 us passive bus
// - New frame waits 300 us passive separator
// - Receive passive 34 to 96 as zero
// - Receive passive 96 to 163 as one
// - Receive active 96 to 163 as zero
// - Receive active 34 to 96 as one
// - Receive active 163 to 239 as start
// - Receive passive 163 to 239 as end-of-data
// - Receive passive 239 or longer as end-of-frame
// - Active 280 us or longer is break
// - Timing from 1.048576 or 1.0 MHz base
// - Receive window edges uncertain by one tick
// - Transmit durations corrected by delay adjust
`ifndef VSC_CFG_SVH
`define VSC_CFG_SVH

// ----------------------------------------------------------------
// Time base
// ----------------------------------------------------------------
`define VSC_ACC_W 24
`define VSC_INC_1M 24'h020c4a
`define VSC_INC_1M05 24'h0225c1
`define VSC_TB_KHZ 1000
`define VSC_CNT_W 9
`define VSC_CNT_MAX 9'h1ff
`define VSC_ADJ_W 4
`define VSC_FIFO_DEPTH 4
`define VSC_T(us) `VSC_CNT_W'((us) * `VSC_TB_KHZ / 1000)

// ----------------------------------------------------------------
// Transmit nominal times, us
// ----------------------------------------------------------------
`define VSC_TX_P0_US 64
`define VSC_TX_P1_US 128
`define VSC_TX_A0_US 128
`define VSC_TX_A1_US 64
`define VSC_TX_SOF_US 200
`define VSC_TX_EOD_US 200
`define VSC_TX_EOF_US 280
`define VSC_TX_IFS_US 300

// ----------------------------------------------------------------
// Receive window bounds, us
// ----------------------------------------------------------------
`define VSC_RX_SHORT_MIN_US 34
`define VSC_RX_LONG_MIN_US 96
`define VSC_RX_LONG_MAX_US 163
`define VSC_RX_SOF_MAX_US 239
`define VSC_RX_EOF_MAX_US 320
`define VSC_RX_BRK_US 280

`endif

//--- common/vsc_pkg.sv
`include "vsc_cfg.svh"

package vsc_pkg;

    // Symbols the user hands to the encoder
    typedef enum logic [1:0] {
        VSC_TX_SOF = 2'h0,
        VSC_TX_DATA = 2'h1,
        VSC_TX_EOD = 2'h2
    } vsc_tx_kind_t;

    typedef struct packed {
        vsc_tx_kind_t kind;
        logic bit_val;
    } vsc_tx_sym_t;

    // Symbols the decoder reports
    typedef enum logic [2:0] {
        VSC_RX_ZERO = 3'h0,
        VSC_RX_ONE = 3'h1,
        VSC_RX_SOF = 3'h2,
        VSC_RX_EOD = 3'h3,
        VSC_RX_EOF = 3'h4,
        VSC_RX_BREAK = 3'h5,
        VSC_RX_INVALID = 3'h6
    } vsc_rx_kind_t;

    typedef struct packed {
        vsc_rx_kind_t kind;
        logic level;
        logic [`VSC_CNT_W-1:0] ticks;
    } vsc_rx_sym_t;

    // Encoder states, one-hot
    typedef enum logic [3:0] {
        VSC_ST_IDLE = 4'h1,
        VSC_ST_SOF = 4'h2,
        VSC_ST_DATA = 4'h4,
        VSC_ST_TAIL = 4'h8
    } vsc_tx_state_t;

endpackage

//--- hw/vsc_tick_gen.sv
`timescale 1ns/1ps
`include "vsc_cfg.svh"

module vsc_tick_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Rate select, high for the 1.048576 MHz base
    input wire logic fast_sel,
    // One-cycle pulse per time-base period
    output logic tick
);
    logic [`VSC_ACC_W-1:0] acc;
    logic [`VSC_ACC_W:0] next_sum;

    // Fractional accumulator: jitter of one core cycle is far below a tick
    assign next_sum = {1'b0, acc} + {1'b0, (fast_sel ? `VSC_INC_1M05 : `VSC_INC_1M)};

    // ----------------------------------------------------------------
    // Phase accumulator, carry out is the tick
    // ----------------------------------------------------------------
    // time base rate
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_sum[`VSC_ACC_W-1:0];
            tick <= next_sum[`VSC_ACC_W];
        end
    end
endmodule // vsc_tick_gen

//--- hw/vsc_fifo.sv
`timescale 1ns/1ps

module vsc_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];
    assign next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);

    // Storage, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and flags; flags are registered so ready never loops back
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != FULL_CNT);
            out_valid <= (next_count != '0);
        end
    end
endmodule // vsc_fifo

//--- hw/vsc_codec.sv
`timescale 1ns/1ps
`include "vsc_cfg.svh"

module vsc_codec (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Configuration
    input wire logic tb_fast_sel,
    input wire logic [`VSC_ADJ_W-1:0] transceiver_delay_adjust,
    // Transmit symbol stream
    input wire logic tx_sym_valid,
    input wire vsc_pkg::vsc_tx_sym_t tx_sym,
    output logic tx_sym_ready,
    // Transmit status
    output logic tx_busy,
    output logic tx_eod_done,
    output logic tx_frame_done,
    output logic tx_error,
    // Receive symbol stream
    output logic rx_valid,
    output vsc_pkg::vsc_rx_sym_t rx_sym,
    output logic rx_bus_idle,
    // Bus pins toward the transceiver, high is active
    input wire logic link_rx_pin,
    output logic link_tx_pin
);
    import vsc_pkg::*;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Half-open window test: lo <= cnt < hi
    function automatic logic in_win(input logic [`VSC_CNT_W-1:0] cnt,
                                    input logic [`VSC_CNT_W-1:0] lo,
                                    input logic [`VSC_CNT_W-1:0] hi);
        in_win = (cnt >= lo) && (cnt < hi);
    endfunction

    // Compensated length: transceiver stretches passive, shortens active
    function automatic logic [`VSC_CNT_W-1:0] tx_dur(input logic level,
                                                    input logic [`VSC_CNT_W-1:0] base,
                                                    input logic [`VSC_ADJ_W-1:0] adj);
        if (level) begin
            tx_dur = base + `VSC_CNT_W'(adj);
        end else begin
            tx_dur = base - `VSC_CNT_W'(adj);
        end
    endfunction

    // Nominal bit length by level and value
    function automatic logic [`VSC_CNT_W-1:0] bit_base(input logic level, input logic val);
        if (level) begin
            bit_base = val ? `VSC_T(`VSC_TX_A1_US) : `VSC_T(`VSC_TX_A0_US);
        end else begin
            bit_base = val ? `VSC_T(`VSC_TX_P1_US) : `VSC_T(`VSC_TX_P0_US);
        end
    endfunction

    // ----------------------------------------------------------------
    // Time base and transmit buffer
    // ----------------------------------------------------------------
    logic tick;
    logic f_valid;
    vsc_tx_sym_t f_data;
    logic f_pop;

    vsc_tick_gen vsc_tick_gen_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fast_sel(tb_fast_sel),
        .tick(tick)
    );

    // Four symbols of slack, so the user may refill at leisure mid-frame
    vsc_fifo #(
        .WIDTH($bits(vsc_tx_sym_t)),
        .DEPTH(`VSC_FIFO_DEPTH)
    ) vsc_fifo_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(tx_sym_valid),
        .in_data(tx_sym),
        .in_ready(tx_sym_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_pop)
    );

    // ----------------------------------------------------------------
    // Receive timing
    // ----------------------------------------------------------------
    logic rx_level;
    logic [`VSC_CNT_W-1:0] rx_cnt;
    logic rx_done;
    logic rx_edge;
    logic [`VSC_CNT_W-1:0] rx_cnt_inc;
    logic rx_emit;
    vsc_rx_kind_t rx_kind;

    assign rx_edge = (link_rx_pin != rx_level);
    assign rx_cnt_inc = (rx_cnt == `VSC_CNT_MAX) ? rx_cnt : rx_cnt + 1'b1;

    // Level tracker and edge-to-edge tick counter
    // edge to edge timing
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_level <= 1'b0;
            rx_cnt <= '0;
        end else if (rx_edge) begin
            rx_level <= link_rx_pin;
            rx_cnt <= '0;
        end else if (tick) begin
            rx_cnt <= rx_cnt_inc;
        end
    end

    // Period already reported early (EOF, break) or idle since reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_done <= 1'b1;
        end else if (rx_edge) begin
            rx_done <= 1'b0;
        end else if (rx_emit) begin
            rx_done <= 1'b1;
        end
    end

    // Classification; long passive and active periods report on timeout
    always_comb begin
        rx_emit = 1'b0;
        rx_kind = VSC_RX_INVALID;
        if (rx_edge && !rx_done) begin
            rx_emit = 1'b1;
            if (rx_level) begin
                if (in_win(rx_cnt, `VSC_T(`VSC_RX_SHORT_MIN_US), `VSC_T(`VSC_RX_LONG_MIN_US))) begin
                    rx_kind = VSC_RX_ONE;
                end else if (in_win(rx_cnt, `VSC_T(`VSC_RX_LONG_MIN_US), `VSC_T(`VSC_RX_LONG_MAX_US))) begin
                    rx_kind = VSC_RX_ZERO;
                end else if (in_win(rx_cnt, `VSC_T(`VSC_RX_LONG_MAX_US), `VSC_T(`VSC_RX_SOF_MAX_US))) begin
                    rx_kind = VSC_RX_SOF;
                end
            end else begin
                if (in_win(rx_cnt, `VSC_T(`VSC_RX_SHORT_MIN_US), `VSC_T(`VSC_RX_LONG_MIN_US))) begin
                    rx_kind = VSC_RX_ZERO;
                end else if (in_win(rx_cnt, `VSC_T(`VSC_RX_LONG_MIN_US), `VSC_T(`VSC_RX_LONG_MAX_US))) begin
                    rx_kind = VSC_RX_ONE;
                end else if (in_win(rx_cnt, `VSC_T(`VSC_RX_LONG_MAX_US), `VSC_T(`VSC_RX_SOF_MAX_US))) begin
                    rx_kind = VSC_RX_EOD;
                end
            end
        end else if (tick && !rx_edge && !rx_done) begin
            if (!rx_level && rx_cnt_inc == `VSC_T(`VSC_RX_SOF_MAX_US)) begin
                rx_emit = 1'b1;
                rx_kind = VSC_RX_EOF;
            end else if (rx_level && rx_cnt_inc == `VSC_T(`VSC_RX_BRK_US)) begin
                rx_emit = 1'b1;
                rx_kind = VSC_RX_BREAK;
            end
        end
    end

    // Registered symbol report; boundaries carry one tick of sampling doubt
    // one tick uncertainty
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_valid <= 1'b0;
            rx_sym <= '0;
        end else begin
            rx_valid <= rx_emit;
            if (rx_emit) begin
                rx_sym.kind <= rx_kind;
                rx_sym.level <= rx_level;
                rx_sym.ticks <= rx_edge ? rx_cnt : rx_cnt_inc;
            end
        end
    end

    // Bus idle once the separator has elapsed on the receive line
    // separator check
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_bus_idle <= 1'b0;
        end else begin
            rx_bus_idle <= !rx_edge && !rx_level && (rx_cnt >= `VSC_T(`VSC_TX_IFS_US));
        end
    end

    // ----------------------------------------------------------------
    // Transmit sequencer
    // ----------------------------------------------------------------
    vsc_tx_state_t tx_state;
    vsc_tx_state_t next_state;
    logic [`VSC_CNT_W-1:0] tx_cnt;
    logic [`VSC_CNT_W-1:0] next_cnt;
    logic next_level;
    logic err_p;
    logic eod_p;
    logic done_p;

    // Decision logic; an empty buffer at a boundary aborts the frame
    always_comb begin
        next_state = tx_state;
        next_cnt = tx_cnt;
        next_level = link_tx_pin;
        f_pop = 1'b0;
        err_p = 1'b0;
        eod_p = 1'b0;
        done_p = 1'b0;
        unique case (tx_state)
            VSC_ST_IDLE: begin
                if (f_valid && f_data.kind != VSC_TX_SOF) begin
                    f_pop = 1'b1;
                    err_p = 1'b1;
                end else if (f_valid && rx_bus_idle) begin
                    f_pop = 1'b1;
                    next_level = 1'b1;
                    next_cnt = tx_dur(1'b1, `VSC_T(`VSC_TX_SOF_US), transceiver_delay_adjust);
                    next_state = VSC_ST_SOF;
                end
            end
            VSC_ST_SOF, VSC_ST_DATA: begin
                if (tick && tx_cnt > `VSC_CNT_W'(1)) begin
                    next_cnt = tx_cnt - 1'b1;
                end else if (tick) begin
                    if (f_valid && f_data.kind == VSC_TX_DATA) begin
                        f_pop = 1'b1;
                        next_level = !link_tx_pin;
                        next_cnt = tx_dur(!link_tx_pin, bit_base(!link_tx_pin, f_data.bit_val),
                                          transceiver_delay_adjust);
                        next_state = VSC_ST_DATA;
                    end else if (f_valid && f_data.kind == VSC_TX_EOD && link_tx_pin &&
                                 tx_state == VSC_ST_DATA) begin
                        f_pop = 1'b1;
                        next_level = 1'b0;
                        next_cnt = '0;
                        next_state = VSC_ST_TAIL;
                    end else begin
                        f_pop = f_valid;
                        err_p = 1'b1;
                        next_level = 1'b0;
                        next_cnt = '0;
                        next_state = VSC_ST_TAIL;
                    end
                end
            end
            VSC_ST_TAIL: begin
                if (tick) begin
                    next_cnt = tx_cnt + 1'b1;
                    if (next_cnt == tx_dur(1'b0, `VSC_T(`VSC_TX_EOD_US), transceiver_delay_adjust)) begin
                        eod_p = 1'b1;
                    end
                    if (next_cnt == tx_dur(1'b0, `VSC_T(`VSC_TX_EOF_US), transceiver_delay_adjust)) begin
                        done_p = 1'b1;
                        next_state = VSC_ST_IDLE;
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state <= VSC_ST_IDLE;
        end else begin
            tx_state <= next_state;
        end
    end

    // Period counter and driven level
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_cnt <= '0;
            link_tx_pin <= 1'b0;
        end else begin
            tx_cnt <= next_cnt;
            link_tx_pin <= next_level;
        end
    end

    // Status pulses and busy level
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_busy <= 1'b0;
            tx_eod_done <= 1'b0;
            tx_frame_done <= 1'b0;
            tx_error <= 1'b0;
        end else begin
            tx_busy <= (next_state != VSC_ST_IDLE);
            tx_eod_done <= eod_p;
            tx_frame_done <= done_p;
            tx_error <= err_p;
        end
    end
endmodule // vsc_codec

//--- testbench/vsc_codec_chk.sv
`timescale 1ns/1ps

module vsc_codec_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Transmit side
    input wire logic tx_busy,
    input wire logic tx_eod_done,
    input wire logic tx_frame_done,
    input wire logic link_tx_pin,
    // Receive side
    input wire logic rx_valid,
    input wire vsc_pkg::vsc_rx_sym_t rx_sym,
    input wire logic rx_bus_idle
);
    import vsc_pkg::*;
    // Core cycle bounds, loose enough for either time base and any delay adjust
    localparam int MIN_RUN = 5700;
    localparam int MAX_ACT = 27500;
    localparam int MIN_EOD = 21000;
    localparam int MIN_EOF = 31000;
    logic [15:0] run_cnt;
    logic tx_prev;
    logic [8:0] tk;
    logic lv;
    vsc_rx_kind_t kd;
    assign tk = rx_sym.ticks;
    assign lv = rx_sym.level;
    assign kd = rx_sym.kind;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Cycles at the present transmit level; saturates so a long idle never wraps
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_cnt <= '0;
            tx_prev <= 1'b0;
        end else begin
            tx_prev <= link_tx_pin;
            run_cnt <= (link_tx_pin != tx_prev) ? '0 : run_cnt + {15'h0, run_cnt != 16'hffff};
        end
    end

    property p_act_max;
        link_tx_pin && !$changed(link_tx_pin) |-> run_cnt < MAX_ACT;
    endproperty
    a_act_max: assert property (p_act_max) else $error("active level held too long");
    property p_min_run;
        $changed(link_tx_pin) && tx_busy && $past(tx_busy) |-> run_cnt >= MIN_RUN;
    endproperty
    a_min_run: assert property (p_min_run) else $error("transmit level too short");
    property p_sof_idle;
        $rose(tx_busy) |-> link_tx_pin && $past(rx_bus_idle);
    endproperty
    a_sof_idle: assert property (p_sof_idle) else $error("frame started without idle bus");
    property p_eod;
        tx_eod_done |-> !link_tx_pin && run_cnt >= MIN_EOD;
    endproperty
    a_eod: assert property (p_eod) else $error("end of data too early");
    property p_eof;
        tx_frame_done |-> !link_tx_pin && run_cnt >= MIN_EOF ##1 !tx_busy;
    endproperty
    a_eof: assert property (p_eof) else $error("end of frame wrong");
    property p_rx_one;
        rx_valid && kd == VSC_RX_ONE |-> (lv ? (tk >= 34 && tk < 96) : (tk >= 96 && tk < 163));
    endproperty
    a_rx_one: assert property (p_rx_one) else $error("one outside window");
    property p_rx_zero;
        rx_valid && kd == VSC_RX_ZERO |-> (lv ? (tk >= 96 && tk < 163) : (tk >= 34 && tk < 96));
    endproperty
    a_rx_zero: assert property (p_rx_zero) else $error("zero outside window");
    property p_rx_sof;
        rx_valid && kd == VSC_RX_SOF |-> lv && tk >= 163 && tk < 239;
    endproperty
    a_rx_sof: assert property (p_rx_sof) else $error("start outside window");
    property p_rx_eof;
        rx_valid && kd == VSC_RX_EOF |-> !lv && tk == 239;
    endproperty
    a_rx_eof: assert property (p_rx_eof) else $error("end of frame count wrong");
    property p_rx_brk;
        rx_valid && kd == VSC_RX_BREAK |-> lv && tk == 280;
    endproperty
    a_rx_brk: assert property (p_rx_brk) else $error("break count wrong");
    property p_rx_pulse;
        rx_valid |=> !rx_valid;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("report longer than one cycle");
endmodule // vsc_codec_chk

//--- testbench/vsc_xcvr_model.sv
`timescale 1ns/1ps

module vsc_xcvr_model (
    // Clock
    input wire logic core_clk,
    // Device side
    input wire logic link_tx_pin,
    output logic link_rx_pin,
    // Other nodes on the bus
    input wire logic remote_drive
);
    // Wired-OR bus, active dominant; released bus sits passive by its pull
    logic [1:0] dly = 2'h0;
    // Two cycles of line and receiver delay, same on both edges
    always_ff @(posedge core_clk) begin
        dly <= {dly[0], link_tx_pin | remote_drive};
    end
    assign link_rx_pin = dly[1];
endmodule // vsc_xcvr_model

//--- testbench/test_vsc_codec.sv
`timescale 1ns/1ps
`include "vsc_cfg.svh"

module test_vsc_codec;
    import vsc_pkg::*;
    localparam int CPT = 125;
    logic core_clk, sys_rst, tb_fast_sel, tx_sym_valid, remote_drive;
    logic [`VSC_ADJ_W-1:0] transceiver_delay_adjust;
    vsc_tx_sym_t tx_sym;
    logic tx_sym_ready, tx_busy, tx_eod_done, tx_frame_done, tx_error;
    logic rx_valid, rx_bus_idle, link_rx_pin, link_tx_pin;
    vsc_rx_sym_t rx_sym;
    int mismatches;
    int total_checks;

    vsc_codec vsc_codec_i (.core_clk(core_clk), .sys_rst(sys_rst), .tb_fast_sel(tb_fast_sel),
        .transceiver_delay_adjust(transceiver_delay_adjust), .tx_sym_valid(tx_sym_valid), .tx_sym(tx_sym),
        .tx_sym_ready(tx_sym_ready), .tx_busy(tx_busy), .tx_eod_done(tx_eod_done),
        .tx_frame_done(tx_frame_done), .tx_error(tx_error), .rx_valid(rx_valid), .rx_sym(rx_sym),
        .rx_bus_idle(rx_bus_idle), .link_rx_pin(link_rx_pin), .link_tx_pin(link_tx_pin));
    vsc_xcvr_model vsc_xcvr_model_i (.core_clk(core_clk), .link_tx_pin(link_tx_pin),
        .link_rx_pin(link_rx_pin), .remote_drive(remote_drive));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Offer one symbol and hold it until the edge that takes it
    task automatic put(input vsc_tx_kind_t k, input logic b);
        int n;
        n = 0;
        tx_sym_valid <= 1'b1;
        tx_sym <= '{kind: k, bit_val: b};
        do begin
            @(posedge core_clk);
            n++;
        end while (tx_sym_ready !== 1'b1 && n < 50);
        chk(n < 50, "symbol not taken");
    endtask

    // Next report must match; one tick of slack for line sampling
    task automatic expect_rx(input vsc_rx_kind_t k, input logic lv, input int t, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (rx_valid !== 1'b1 && n < lim);
        chk(n < lim && rx_sym.kind === k && rx_sym.level === lv && rx_sym.ticks >= t - 1
            && rx_sym.ticks <= t + 1, "receive symbol wrong");
    endtask

    // Drive a new bus level while the period just closed is judged
    task automatic seg(input logic lv, input int n, input vsc_rx_kind_t k, input logic plv, input int t);
        fork
            begin
                remote_drive <= lv;
                repeat (n * CPT) @(posedge core_clk);
            end
            expect_rx(k, plv, t, 60);
        join
    endtask

    // Cycles until the pin reaches a level (sel 0) or a done pulse shows
    task automatic wait_for(input int sel, input logic lv, output int c);
        c = 0;
        do begin
            @(negedge core_clk);
            c++;
        end while ((sel == 0 ? link_tx_pin : sel == 1 ? tx_eod_done : tx_frame_done) !== lv && c < 50000);
    endtask

    function automatic logic near(input int c, input int t);
        real k;
        k = 125.0 / 1.048576;
        return (c > (t - 2) * k) && (c < (t + 2) * k);
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fill();
        put(VSC_TX_SOF, 1'b0);
        put(VSC_TX_DATA, 1'b1);
        put(VSC_TX_DATA, 1'b0);
        put(VSC_TX_DATA, 1'b0);
        tx_sym_valid <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk(tx_sym_ready === 1'b0 && tx_busy === 1'b0, "queue not full or sent early");
        @(posedge core_clk);
    endtask

    task automatic t_receive();
        repeat (10 * CPT) @(posedge core_clk);
        remote_drive <= 1'b1;
        repeat (20 * CPT) @(posedge core_clk);
        seg(1'b0, 64, VSC_RX_INVALID, 1'b1, 20);
        seg(1'b1, 64, VSC_RX_ZERO, 1'b0, 64);
        seg(1'b0, 200, VSC_RX_ONE, 1'b1, 64);
        fork
            seg(1'b1, 300, VSC_RX_EOD, 1'b0, 200);
            begin
                repeat (250 * CPT) @(posedge core_clk);
                expect_rx(VSC_RX_BREAK, 1'b1, 280, 40 * CPT);
            end
        join
        remote_drive <= 1'b0;
        expect_rx(VSC_RX_EOF, 1'b0, 239, 245 * CPT);
        @(posedge core_clk);
        tb_fast_sel <= 1'b1;
    endtask

    // Queued frame goes out on the faster base with a delay adjust of 3
    task automatic t_transmit();
        int c;
        wait_for(0, 1'b1, c);
        fork
            begin
                wait_for(0, 1'b0, c);
                chk(near(c, 203), "start length wrong");
                wait_for(0, 1'b1, c);
                chk(near(c, 125), "passive one length wrong");
                wait_for(0, 1'b0, c);
                chk(near(c, 131), "active zero length wrong");
                wait_for(0, 1'b1, c);
                chk(near(c, 61), "passive zero length wrong");
                wait_for(0, 1'b0, c);
                chk(near(c, 67), "active one length wrong");
                wait_for(1, 1'b1, c);
                chk(near(c, 197), "end of data length wrong");
                wait_for(2, 1'b1, c);
                chk(near(c, 80), "end of frame length wrong");
                @(negedge core_clk);
                chk(tx_busy === 1'b0 && link_tx_pin === 1'b0, "busy after frame");
            end
            begin
                expect_rx(VSC_RX_SOF, 1'b1, 203, 300 * CPT);
                expect_rx(VSC_RX_ONE, 1'b0, 125, 200 * CPT);
                expect_rx(VSC_RX_ZERO, 1'b1, 131, 200 * CPT);
                expect_rx(VSC_RX_ZERO, 1'b0, 61, 200 * CPT);
                expect_rx(VSC_RX_ONE, 1'b1, 67, 200 * CPT);
                expect_rx(VSC_RX_EOF, 1'b0, 239, 300 * CPT);
            end
            // Refill once the queue has drained to one
            begin
                @(posedge link_tx_pin);
                put(VSC_TX_DATA, 1'b1);
                put(VSC_TX_EOD, 1'b0);
                tx_sym_valid <= 1'b0;
            end
        join
    endtask

    task automatic t_refuse();
        int c;
        @(posedge core_clk);
        put(VSC_TX_DATA, 1'b1);
        tx_sym_valid <= 1'b0;
        c = 0;
        do begin
            @(negedge core_clk);
            c++;
        end while (tx_error !== 1'b1 && c < 40 * CPT);
        chk(c < 40 * CPT && tx_busy === 1'b0 && link_tx_pin === 1'b0, "stray data not refused");
    endtask

    initial begin
        sys_rst = 1'b1;
        tb_fast_sel = 1'b0;
        transceiver_delay_adjust = 4'h3;
        tx_sym_valid = 1'b0;
        tx_sym = '0;
        remote_drive = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (10) @(posedge core_clk);
        chk(tx_sym_ready === 1'b0 && link_tx_pin === 1'b0 && rx_valid === 1'b0, "outputs active in reset");
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_fill();
        t_receive();
        t_transmit();
        t_refuse();
        stop_test();
    end

    // Whole run needs about 1.8 ms of bus time
    initial begin
        #2500000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule // test_vsc_codec

bind vsc_codec vsc_codec_chk vsc_codec_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .tx_busy(tx_busy),
    .tx_eod_done(tx_eod_done), .tx_frame_done(tx_frame_done), .link_tx_pin(link_tx_pin),
    .rx_valid(rx_valid), .rx_sym(rx_sym), .rx_bus_idle(rx_bus_idle));
